// *** verilog/spi_port_map.svh ***
// Constants of the four-wire serial port: role codes, dividers, counts.
// Assumes inclusion by bare name from the design files.
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH

// Role and clock source codes of the role_clock_select field
`define ROLE_MASTER_DIV4 3'h0
`define ROLE_MASTER_DIV16 3'h1
`define ROLE_MASTER_DIV64 3'h2
`define ROLE_MASTER_SUB 3'h3
`define ROLE_MASTER_TIMER 3'h4
`define ROLE_SLAVE 3'h5

// Half periods of the serial clock in system cycles per divider code
`define HALF_DIV4 6'h02
`define HALF_DIV16 6'h08
`define HALF_DIV64 6'h20

// Edge index of the last of sixteen clock edges in one byte
`define EDGE_LAST 4'hF

// Half period of the partner's own serial clock in system cycles; it must
// exceed the round trip through two three-stage samplers, about ten cycles
`define PARTNER_HALF 6'h10

// Receive buffer shape
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16

`endif

// *** verilog/spi_port_pkg.sv ***
// Types and shared helpers of the four-wire serial port.
// Assumes both link ends import it whole.
`default_nettype none
package spi_port_pkg;

    typedef enum {st_idle, st_wait, st_setup, st_shift, st_hold} link_state_t;

    // Shift one bit into a byte in the chosen order
    function automatic logic [7:0] shift_in(input logic [7:0] b, input logic bit_in, input logic msb_first);
        return msb_first ? {b[6:0], bit_in} : {bit_in, b[7:1]};
    endfunction

    // Bit that stands on the data line for a byte
    function automatic logic out_bit(input logic [7:0] b, input logic msb_first);
        return msb_first ? b[7] : b[0];
    endfunction

    // Filtered level: follows the third stage once the second agrees
    function automatic logic [2:0] settle(input logic [2:0] s2, input logic [2:0] s3, input logic [2:0] filt);
        return (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
    endfunction

    // Edge select set captures on leading (even) edges, clear on trailing
    function automatic logic is_capture(input logic [3:0] e, input logic ceg);
        return e[0] == ~ceg;
    endfunction

    // Data line advances on the other kind of edge, never on the very first
    function automatic logic is_advance(input logic [3:0] e, input logic ceg);
        return (e[0] == ceg) && (e != 4'h0);
    endfunction

endpackage
`default_nettype wire

// *** verilog/spi_link_if.sv ***
// Four-wire serial link between the port and its partner.
// Assumes each end drives a pin only while its enable is high; an undriven
// line reads high, as a pull-up would make it.
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
    logic dev_sck_out;
    logic dev_sck_oe;
    logic dev_sdo_out;
    logic dev_sdo_oe;
    logic dev_ss_out;
    logic dev_ss_oe;
    logic par_sck_out;
    logic par_sck_oe;
    logic par_sdo_out;
    logic par_sdo_oe;
    logic par_ss_out;
    logic par_ss_oe;
    logic sck;
    logic ss_n;
    logic dev_to_par;
    logic par_to_dev;

    // Wire levels resolved from the enables
    assign sck = dev_sck_oe ? dev_sck_out : (par_sck_oe ? par_sck_out : 1'b1);
    assign ss_n = dev_ss_oe ? dev_ss_out : (par_ss_oe ? par_ss_out : 1'b1);
    assign dev_to_par = dev_sdo_oe ? dev_sdo_out : 1'b1;
    assign par_to_dev = par_sdo_oe ? par_sdo_out : 1'b1;

    modport device (output dev_sck_out, dev_sck_oe, dev_sdo_out, dev_sdo_oe, dev_ss_out, dev_ss_oe,
                    input sck, ss_n, par_to_dev);
    modport partner (output par_sck_out, par_sck_oe, par_sdo_out, par_sdo_oe, par_ss_out, par_ss_oe,
                     input sck, ss_n, dev_to_par);
endinterface
`default_nettype wire

// *** verilog/spi_port_device.sv ***
// Serial port end of the link: master or slave, with a receive FIFO.
// Assumes control inputs are steady during a transfer and that the link
// pins are asynchronous to i_clk.
// Notes on behaviour
// - Four lines: clock, data in, out, select
// - Select enable lets select line control port
// - Both enables: data out idles high
// - Master idles clock at inverse of polarity level
// - Slave leaves clock line undriven
// - Port disable releases all four pins
// - Master clocks only after data write
// - Slave byte waits for external clock, select
// - Software sets role before enabling port
// - Bit order equal on both ends
// - Received byte latched only when complete
// - Software rewrites byte after a collision
// - Completion flag ends transfer, software clears
// - Write during transfer dropped, collision set
// - Collision flag sticky until software clears
// - Role codes: five masters, slave, off
// - Polarity sets idle, edge select capture
// - Master asserts select before first clock
// - Early select rise sets incomplete and done
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Receive FIFO: full stalls the master before it starts a byte
module spi_rx_fifo
    import spi_port_pkg::*;
#(
    parameter int WIDTH = `FIFO_WIDTH,
    parameter int DEPTH = `FIFO_DEPTH
)
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire push;
    wire pop;

    // Handshakes on both sides
    assign o_in_ready = count_reg != (AW+1)'(DEPTH);
    assign o_out_valid = count_reg != '0;
    assign o_out_data = mem[rd_ptr_reg];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    // Pointers and fill count
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(pop);
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; only written words are ever read
    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr_reg] <= i_in_data;
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module spi_port_device
    import spi_port_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [2:0] i_role_clock_select,
    input wire logic i_port_enable,
    input wire logic i_select_pin_enable,
    input wire logic i_clock_polarity,
    input wire logic i_capture_edge_select,
    input wire logic i_bit_order_select,
    input wire logic i_sub_clock_tick,
    input wire logic i_timer_match_tick,
    input wire logic i_irq_enable,
    input wire logic i_data_wr,
    input wire logic [7:0] i_data_wr_byte,
    input wire logic i_clear_done,
    input wire logic i_clear_collision,
    input wire logic i_clear_incomplete,
    output logic [7:0] o_serial_data,
    output logic o_transfer_done_flag,
    output logic o_write_collision_flag,
    output logic o_incomplete_flag,
    output logic o_irq,
    output logic o_rx_valid,
    input wire logic i_rx_ready,
    output logic [7:0] o_rx_data,
    spi_link_if.device link
);
    link_state_t state_reg;
    link_state_t state_next;
    logic [2:0] s1_reg;
    logic [2:0] s2_reg;
    logic [2:0] s3_reg;
    logic [2:0] filt_reg;
    logic [2:0] prev_reg;
    logic [5:0] div_reg;
    logic [3:0] edge_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic [7:0] serial_data_reg;
    logic done_reg;
    logic collision_reg;
    logic incomplete_reg;
    logic irq_reg;
    logic sck_reg;
    logic sdo_reg;
    logic sdo_oe_reg;
    logic ss_reg;
    logic ss_oe_reg;
    logic sck_oe_reg;
    wire active;
    wire is_master;
    wire is_slave;
    wire [5:0] half_limit;
    wire tick;
    wire sck_edge;
    wire ss_rise;
    wire slave_sel;
    wire master_edge;
    wire slave_edge;
    wire link_edge;
    wire do_capture;
    wire do_advance;
    wire byte_end;
    wire slave_abort;
    wire busy;
    wire wr_accept;
    wire collision_hit;
    wire fifo_ready;
    wire idle_level;
    wire [7:0] rx_next;
    wire [7:0] tx_next;
    wire done_next;
    wire sdo_live;

    ////////////////////////////////////////////////////////////////////////////
    // Role decode: codes 11x switch the port off like a clear enable
    assign active = i_port_enable & (i_role_clock_select <= `ROLE_SLAVE);
    assign is_slave = active & (i_role_clock_select == `ROLE_SLAVE);
    assign is_master = active & ~is_slave;
    assign idle_level = ~i_clock_polarity;

    // Master bit clock source per role code
    assign half_limit = (i_role_clock_select == `ROLE_MASTER_DIV4) ? `HALF_DIV4 :
                        (i_role_clock_select == `ROLE_MASTER_DIV16) ? `HALF_DIV16 : `HALF_DIV64;
    assign tick = (i_role_clock_select == `ROLE_MASTER_SUB) ? i_sub_clock_tick :
                  (i_role_clock_select == `ROLE_MASTER_TIMER) ? i_timer_match_tick :
                  (div_reg == half_limit - 6'h01);

    // Pin sampling: bit 0 clock, bit 1 data in, bit 2 select
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            s1_reg <= 3'h7;
            s2_reg <= 3'h7;
            s3_reg <= 3'h7;
            filt_reg <= 3'h7;
            prev_reg <= 3'h7;
        end
        else
        begin
            s1_reg <= {link.ss_n, link.par_to_dev, link.sck};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= settle(s2_reg, s3_reg, filt_reg);
            prev_reg <= filt_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge events; select without its enable has no say at all
    assign sck_edge = filt_reg[0] ^ prev_reg[0];
    assign ss_rise = filt_reg[2] & ~prev_reg[2];
    assign slave_sel = ~i_select_pin_enable | ~filt_reg[2];
    assign master_edge = is_master & (state_reg == st_shift) & tick;
    assign slave_edge = is_slave & slave_sel & sck_edge;
    assign link_edge = master_edge | slave_edge;
    assign do_capture = link_edge & is_capture(edge_reg, i_capture_edge_select);
    assign do_advance = link_edge & is_advance(edge_reg, i_capture_edge_select);
    assign byte_end = link_edge & (edge_reg == `EDGE_LAST);
    assign slave_abort = is_slave & i_select_pin_enable & ss_rise & (state_reg == st_shift);

    // Data path; the master slows data in by the sampling latency
    assign rx_next = shift_in(rx_reg, filt_reg[1], i_bit_order_select);
    assign busy = state_reg != st_idle;
    assign wr_accept = i_data_wr & ~busy;
    assign collision_hit = i_data_wr & busy;
    assign tx_next = wr_accept ? i_data_wr_byte :
                     (do_advance ? shift_in(tx_reg, 1'b1, i_bit_order_select) : tx_reg);
    assign done_next = byte_end | slave_abort | (done_reg & ~i_clear_done);
    assign sdo_live = (state_next != st_idle && state_next != st_wait) | (is_slave & slave_sel);

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequence; the master waits for FIFO room before selecting
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            st_idle:
                if (is_master & wr_accept)
                    state_next = st_wait;
                else if (slave_edge)
                    state_next = st_shift;
            st_wait:
                if (!is_master)
                    state_next = st_idle;
                else if (fifo_ready)
                    state_next = st_setup;
            st_setup:
                if (!is_master)
                    state_next = st_idle;
                else if (tick)
                    state_next = st_shift;
            st_shift:
                if (!active || slave_abort)
                    state_next = st_idle;
                else if (byte_end)
                    state_next = is_master ? st_hold : st_idle;
            st_hold:
                if (!is_master || tick)
                    state_next = st_idle;
            default:
                state_next = st_idle;
        endcase
    end

    // Sequence, divider and edge count
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            state_reg <= st_idle;
            div_reg <= 6'h00;
            edge_reg <= 4'h0;
        end
        else
        begin
            state_reg <= state_next;
            div_reg <= (state_reg == st_idle || state_reg == st_wait || tick) ? 6'h00 : div_reg + 6'h01;
            edge_reg <= (state_next == st_idle) ? 4'h0 : edge_reg + 4'(link_edge);
        end
    end

    // Shift buffers and the readable data register
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            tx_reg <= 8'hFF;
            rx_reg <= 8'h00;
            serial_data_reg <= 8'h00;
        end
        else
        begin
            tx_reg <= tx_next;
            rx_reg <= do_capture ? rx_next : rx_reg;
            if (byte_end)
                serial_data_reg <= do_capture ? rx_next : rx_reg;
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            done_reg <= 1'b0;
            collision_reg <= 1'b0;
            incomplete_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            done_reg <= done_next;
            collision_reg <= collision_hit | (collision_reg & ~i_clear_collision);
            incomplete_reg <= slave_abort | (incomplete_reg & ~i_clear_incomplete);
            irq_reg <= done_next & i_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers, all registered so the lines never glitch
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            sck_reg <= 1'b1;
            sck_oe_reg <= 1'b0;
            sdo_reg <= 1'b1;
            sdo_oe_reg <= 1'b0;
            ss_reg <= 1'b1;
            ss_oe_reg <= 1'b0;
        end
        else
        begin
            sck_reg <= (master_edge ? ~sck_reg : (state_reg == st_shift ? sck_reg : idle_level));
            sck_oe_reg <= is_master;
            sdo_reg <= sdo_live ? out_bit(tx_next, i_bit_order_select) : 1'b1;
            sdo_oe_reg <= active;
            ss_reg <= ~(is_master & (state_next == st_setup || state_next == st_shift || state_next == st_hold));
            ss_oe_reg <= is_master & i_select_pin_enable;
        end
    end

    assign link.dev_sck_out = sck_reg;
    assign link.dev_sck_oe = sck_oe_reg;
    assign link.dev_sdo_out = sdo_reg;
    assign link.dev_sdo_oe = sdo_oe_reg;
    assign link.dev_ss_out = ss_reg;
    assign link.dev_ss_oe = ss_oe_reg;
    assign o_serial_data = serial_data_reg;
    assign o_transfer_done_flag = done_reg;
    assign o_write_collision_flag = collision_reg;
    assign o_incomplete_flag = incomplete_reg;
    assign o_irq = irq_reg;

    // Each finished byte also enters the receive FIFO if it has room
    spi_rx_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) rx_fifo
    (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_in_valid(byte_end),
        .o_in_ready(fifo_ready),
        .i_in_data(do_capture ? rx_next : rx_reg),
        .o_out_valid(o_rx_valid),
        .i_out_ready(i_rx_ready),
        .o_out_data(o_rx_data)
    );
endmodule
`default_nettype wire

// *** verilog/spi_port_partner.sv ***
// Far end of the link: an external master or slave, one byte at a time.
// Assumes its clock is i_clk and the link pins are asynchronous to it.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_map.svh"

module spi_port_partner
    import spi_port_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_is_master,
    input wire logic i_clock_polarity,
    input wire logic i_capture_edge_select,
    input wire logic i_bit_order_select,
    input wire logic i_start,
    input wire logic [7:0] i_tx_byte,
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_rx_byte,
    spi_link_if.partner link
);
    localparam logic [5:0] HALF_LAST = `PARTNER_HALF - 6'h01;
    link_state_t state_reg;
    link_state_t state_next;
    logic [2:0] s1_reg;
    logic [2:0] s2_reg;
    logic [2:0] s3_reg;
    logic [2:0] filt_reg;
    logic [2:0] prev_reg;
    logic [5:0] div_reg;
    logic [3:0] edge_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic [7:0] rx_out_reg;
    logic done_reg;
    logic sck_reg;
    logic ss_reg;
    logic sdo_reg;
    logic sdo_oe_reg;
    wire tick;
    wire selected;
    wire link_edge;
    wire do_capture;
    wire byte_end;
    wire [7:0] rx_next;
    wire [7:0] tx_next;

    ////////////////////////////////////////////////////////////////////////////
    // Events; as slave it always obeys select, so a bench master must drive it
    assign tick = div_reg == HALF_LAST;
    assign selected = ~filt_reg[2];
    assign link_edge = i_is_master ? (state_reg == st_shift) & tick
                                   : selected & (filt_reg[0] ^ prev_reg[0]);
    assign do_capture = link_edge & is_capture(edge_reg, i_capture_edge_select);
    assign byte_end = link_edge & (edge_reg == `EDGE_LAST);
    assign rx_next = shift_in(rx_reg, filt_reg[1], i_bit_order_select);
    assign tx_next = (i_start && state_reg == st_idle) ? i_tx_byte :
                     ((link_edge & is_advance(edge_reg, i_capture_edge_select)) ?
                      shift_in(tx_reg, 1'b1, i_bit_order_select) : tx_reg);

    // Sequence: select first, then sixteen clock edges, then release
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            st_idle:
                if (i_is_master && i_start)
                    state_next = st_setup;
                else if (!i_is_master && link_edge)
                    state_next = st_shift;
            st_setup:
                if (tick)
                    state_next = st_shift;
            st_shift:
                if (byte_end)
                    state_next = i_is_master ? st_hold : st_idle;
                else if (!i_is_master && !selected)
                    state_next = st_idle;
            st_hold:
                if (tick)
                    state_next = st_idle;
            default:
                state_next = st_idle;
        endcase
    end

    // Pin sampling, three stages and a settle filter
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            s1_reg <= 3'h7;
            s2_reg <= 3'h7;
            s3_reg <= 3'h7;
            filt_reg <= 3'h7;
            prev_reg <= 3'h7;
        end
        else
        begin
            s1_reg <= {link.ss_n, link.dev_to_par, link.sck};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= settle(s2_reg, s3_reg, filt_reg);
            prev_reg <= filt_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequence, divider, shift data and results
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            state_reg <= st_idle;
            div_reg <= 6'h00;
            edge_reg <= 4'h0;
            tx_reg <= 8'hFF;
            rx_reg <= 8'h00;
            rx_out_reg <= 8'h00;
            done_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            div_reg <= (state_reg == st_idle || tick) ? 6'h00 : div_reg + 6'h01;
            edge_reg <= (state_next == st_idle) ? 4'h0 : edge_reg + 4'(link_edge);
            tx_reg <= tx_next;
            rx_reg <= do_capture ? rx_next : rx_reg;
            rx_out_reg <= byte_end ? (do_capture ? rx_next : rx_reg) : rx_out_reg;
            done_reg <= byte_end;
        end
    end

    // Pins: the master end makes the clock by dividing its own
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            sck_reg <= 1'b1;
            ss_reg <= 1'b1;
            sdo_reg <= 1'b1;
            sdo_oe_reg <= 1'b0;
        end
        else
        begin
            sck_reg <= (i_is_master && link_edge) ? ~sck_reg :
                       (state_reg == st_shift ? sck_reg : ~i_clock_polarity);
            ss_reg <= ~(i_is_master && state_next != st_idle);
            sdo_reg <= out_bit(tx_next, i_bit_order_select);
            sdo_oe_reg <= i_is_master | selected;
        end
    end

    assign link.par_sck_out = sck_reg;
    assign link.par_sck_oe = i_is_master;
    assign link.par_ss_out = ss_reg;
    assign link.par_ss_oe = i_is_master;
    assign link.par_sdo_out = sdo_reg;
    assign link.par_sdo_oe = sdo_oe_reg;
    assign o_busy = state_reg != st_idle;
    assign o_done = done_reg;
    assign o_rx_byte = rx_out_reg;
endmodule
`default_nettype wire

// *** tb/spi_link_asserts.sv ***
// Assertions on the four-wire link between the two ends.
// Assumes the bench wires the interface signals in by name.
`timescale 1ns/1ps
`default_nettype none
module spi_link_asserts (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic dev_to_par,
    input wire logic dev_sck_oe,
    input wire logic par_sck_oe,
    input wire logic dev_ss_oe,
    input wire logic par_ss_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic [4:0] edge_cnt;
    // Clock edges in a frame; deselect clears the count
    always_ff @(posedge i_clk)
    begin
        if (ss_n)
            edge_cnt <= 5'h00;
        else if ($changed(sck))
            edge_cnt <= edge_cnt + 5'h01;
    end
    ////////////////////////////////
    // Oe changes are excluded: an idle level may move when a pin is taken over
    AST_SCK_ONE_DRIVER: assert property (!(dev_sck_oe && par_sck_oe))
        else $error("two clock drivers");
    AST_SS_ONE_DRIVER: assert property (!(dev_ss_oe && par_ss_oe))
        else $error("two select drivers");
    AST_SDO_IDLE_HIGH: assert property (ss_n[*3] ##0 dev_ss_oe |-> dev_to_par)
        else $error("data out low at idle");
    AST_SCK_IDLE_STILL: assert property (
        dev_ss_oe && ss_n && $past(ss_n) && $stable(dev_sck_oe) |-> $stable(sck))
        else $error("idle clock moved");
    AST_SCK_ONLY_FRAMED: assert property (
        $changed(sck) && $stable(dev_sck_oe) && $stable(par_sck_oe) |-> !ss_n)
        else $error("clock edge unselected");
    AST_SELECT_FIRST: assert property ($fell(ss_n) && dev_ss_oe |-> $stable(sck))
        else $error("clock moved with select");
    AST_SIXTEEN_EDGES: assert property ($rose(ss_n) && $stable(par_ss_oe) |-> edge_cnt == 5'h10)
        else $error("frame edge count wrong");
    AST_FRAME_BOUNDED: assert property ($fell(ss_n) |-> ##[1:1000] $rose(ss_n))
        else $error("frame never ended");
    // Each end leading a frame, and a whole byte
    cover property ($fell(ss_n) && dev_ss_oe);
    cover property ($fell(ss_n) && par_ss_oe);
    cover property ($rose(ss_n) && edge_cnt == 5'h10);
endmodule
`default_nettype wire

// *** tb/spi_master_slave_port_tb.sv ***
// Bench: device end against partner end over one link.
// Assumes design and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %h", $time, g); end end
module spi_master_slave_port_tb;
    logic i_clk = 0, i_resetn = 0, i_port_enable = 0, i_select_pin_enable = 1, i_clock_polarity = 0;
    logic i_capture_edge_select = 0, i_bit_order_select = 0, i_sub_clock_tick = 0, i_timer_match_tick = 0;
    logic i_irq_enable = 1, i_data_wr = 0, i_clear_done = 0, i_clear_collision = 0, i_clear_incomplete = 0;
    logic i_rx_ready = 0, p_master = 0, p_start = 0, p_busy, p_done, o_rx_valid, o_irq, o_incomplete_flag;
    logic o_transfer_done_flag, o_write_collision_flag;
    logic [2:0] i_role_clock_select = 3'h7;
    logic [7:0] i_data_wr_byte = 8'h00, p_tx = 8'h00, o_serial_data, o_rx_data, p_rx;
    int errors = 0, n_checks = 0, cyc = 0, k, n;
    spi_link_if link();
    spi_port_device spi_port_device_i (.*);
    spi_port_partner spi_port_partner_i (.i_clk, .i_resetn, .i_is_master(p_master), .i_clock_polarity,
        .i_capture_edge_select, .i_bit_order_select, .i_start(p_start), .i_tx_byte(p_tx), .o_busy(p_busy),
        .o_done(p_done), .o_rx_byte(p_rx), .link);
    spi_link_asserts spi_link_asserts_i (.i_clk, .i_resetn, .sck(link.sck), .ss_n(link.ss_n),
        .dev_to_par(link.dev_to_par), .dev_sck_oe(link.dev_sck_oe), .par_sck_oe(link.par_sck_oe),
        .dev_ss_oe(link.dev_ss_oe), .par_ss_oe(link.par_ss_oe));
    ////////////////////////////////
    initial
    begin
        forever #50 i_clk = ~i_clk;
    end
    // Tick sources; the limit is about ten times the expected run
    always @(negedge i_clk)
    begin
        cyc++;
        i_sub_clock_tick = (cyc % 16 == 0);
        i_timer_match_tick = (cyc % 24 == 0);
        if (cyc == 20000)
        begin
            errors++;
            give_verdict();
        end
    end
    ////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Port is off while settings move; enabling it can still step the clock line to its idle level
    task automatic cfg(input logic [2:0] code, input logic [1:0] mode);
        {i_port_enable, p_master} = 2'h0;
        repeat (2) @(negedge i_clk);
        {i_clock_polarity, i_capture_edge_select, i_bit_order_select} = {mode, mode[0]};
        i_role_clock_select = code;
        @(negedge i_clk) p_master = (code == 3'h5);
        @(negedge i_clk) i_port_enable = 1;
        @(negedge i_clk);
    endtask
    // One byte each way; coll adds a write in mid-transfer
    task automatic xfer(input logic [7:0] a, input logic [7:0] b, input logic coll, input logic dat);
        {p_tx, i_data_wr_byte, p_start, i_data_wr} = {b, a, 2'h3};
        @(negedge i_clk) {p_start, i_data_wr} = 2'h0;
        if (coll)
        begin
            repeat (60) @(negedge i_clk);
            {i_data_wr_byte, i_data_wr} = {8'hA5, 1'b1};
            @(negedge i_clk) i_data_wr = 0;
        end
        for (n = 0; n < 2000 && !o_transfer_done_flag; n++) @(negedge i_clk);
        repeat (8) @(negedge i_clk);
        `CHK({o_transfer_done_flag, o_irq}, 2'h3)
        `CHK(o_write_collision_flag, coll)
        if (dat)
        begin
            `CHK(o_serial_data, b)
            `CHK(p_rx, a)
        end
        {i_clear_done, i_clear_collision} = 2'h3;
        @(negedge i_clk) {i_clear_done, i_clear_collision} = 2'h0;
        repeat (2) @(negedge i_clk);
        `CHK({o_transfer_done_flag, o_write_collision_flag, o_irq}, 3'h0)
        $display("test ended, checks %0d", n_checks);
    endtask
    ////////////////////////////////
    // Master codes, receive queue, slave role, fast dividers last
    initial
    begin
        repeat (20) @(negedge i_clk);
        i_resetn = 1;
        for (k = 0; k < 3; k++)
        begin
            cfg(3'h2 + k[2:0], k[1:0]);
            xfer(8'h35 + k[7:0], 8'h90 + k[7:0], k == 0, 1'b1);
        end
        for (k = 0; k < 3; k++)
        begin
            `CHK({o_rx_valid, o_rx_data}, {1'b1, 8'h90 + k[7:0]})
            @(negedge i_clk) i_rx_ready = 1;
            @(negedge i_clk) i_rx_ready = 0;
        end
        `CHK(o_rx_valid, 1'b0)
        cfg(3'h5, 2'h0);
        xfer(8'hC3, 8'h6B, 1'b0, 1'b1);
        // Releasing the partner's pins lifts select in mid-byte
        p_start = 1;
        @(negedge i_clk) p_start = 0;
        repeat (99) @(negedge i_clk);
        p_master = 0;
        repeat (12) @(negedge i_clk);
        `CHK({o_incomplete_flag, o_transfer_done_flag, o_irq, o_serial_data}, {3'h7, 8'h6B})
        {i_clear_done, i_clear_incomplete} = 2'h3;
        @(negedge i_clk) {i_clear_done, i_clear_incomplete} = 2'h0;
        @(negedge i_clk) `CHK(o_incomplete_flag, 1'b0)
        $display("test ended, checks %0d", n_checks);
        for (k = 0; k < 2; k++)
        begin
            cfg(k[2:0], 2'h3);
            xfer(8'h35, 8'h00, 1'b0, 1'b0);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
